// file: core/light_prox_params.svh
// Constants shared by the light and proximity measurement sequencer.
// Assumes inclusion by bare name from files under core/.
`ifndef LIGHT_PROX_PARAMS_SVH
`define LIGHT_PROX_PARAMS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define INTEG_BASE_NS 24400
`define INTEG_BASE_CYC ((`INTEG_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RATE_UNIT_CYC 100000

// ---------------------------------------------------------------
// Channel configuration word, one per channel
// ---------------------------------------------------------------
`define CH_COUNT 6
`define CFG_W 16
`define FLD_LED_ONE 0
`define FLD_LED_TWO 1
`define FLD_LED_THREE 2
`define FLD_BANK 3
`define FLD_PD_LO 4
`define FLD_INTEG_LO 6
`define FLD_HIGH_RANGE 10
`define FLD_MODE24 11
`define FLD_DARK_SUB 12
`define FLD_IRQ_LO 13

// ---------------------------------------------------------------
// Result codes and reset values
// ---------------------------------------------------------------
`define RES_W 24
`define OVF_CODE16 24'h00ffff
`define OVF_CODE24 24'h7fffff
`define RESULT_RST 24'h000000

`endif

// file: core/light_prox_pkg.sv
// Types for the light and proximity measurement sequencer.
// Assumes nothing of its surroundings.
package light_prox_pkg;
	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_SETUP = 5'h02,
		S_CONV  = 5'h04,
		S_STORE = 5'h08,
		S_DONE  = 5'h10
	} seq_state_t;

	typedef enum logic [1:0] {
		IRQ_OFF    = 2'h0,
		IRQ_ABOVE  = 2'h1,
		IRQ_BELOW  = 2'h2,
		IRQ_WINDOW = 2'h3
	} irq_mode_t;
endpackage

// file: core/conv_if.sv
// Link between the sequencer and its conversion timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
	logic start;
	logic [3:0] integ_code;
	logic dark_sub;
	logic mode24;
	logic done;
	logic sat;
	logic [23:0] value;

	modport seq (output start, output integ_code, output dark_sub,
		output mode24, input done, input sat, input value);
	modport conv (input start, input integ_code, input dark_sub,
		input mode24, output done, output sat, output value);
endinterface
`default_nettype wire

// file: core/adc_integ_conv.sv
// Conversion timer: waits out the integration time, then captures both
// converter words. Assumes the converter pins are asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "light_prox_params.svh"
module adc_integ_conv #(
	parameter int INTEG_BASE_CYC = `INTEG_BASE_CYC
) (
	// Clock and synchronised reset
	input wire logic ref_clk,
	input wire logic rst_q_n,
	// Converter pins
	input wire logic [23:0] sig_pin,
	input wire logic [23:0] dark_pin,
	input wire logic sat_pin,
	// Sequencer side
	conv_if.conv cv
);
	logic [48:0] meta_reg;
	logic [48:0] sync_reg;
	logic [27:0] cnt_reg;
	logic run_reg;
	logic done_reg;
	logic sat_reg;
	logic [23:0] value_reg;
	logic [27:0] target;
	logic [23:0] sig_s;
	logic [23:0] dark_s;
	logic [23:0] diff;

	always_ff @(posedge ref_clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= {sat_pin, dark_pin, sig_pin};
			sync_reg <= meta_reg;
		end
	end

	assign sig_s = sync_reg[23:0];
	assign dark_s = sync_reg[47:24];
	assign target = 28'(INTEG_BASE_CYC) << cv.integ_code;
	assign diff = (cv.dark_sub && sig_s > dark_s) ? sig_s - dark_s :
		(cv.dark_sub ? 24'h000000 : sig_s);

	always_ff @(posedge ref_clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			cnt_reg <= 28'h0000000;
			run_reg <= 1'b0;
			done_reg <= 1'b0;
			sat_reg <= 1'b0;
			value_reg <= `RESULT_RST;
		end else begin
			done_reg <= 1'b0;
			if (cv.start) begin
				run_reg <= 1'b1;
				cnt_reg <= 28'h0000000;
			end else if (run_reg) begin
				cnt_reg <= cnt_reg + 28'h0000001;
				if (cnt_reg == target - 28'h0000001) begin
					run_reg <= 1'b0;
					done_reg <= 1'b1;
					value_reg <= cv.mode24 ? diff : {8'h00, diff[15:0]};
					sat_reg <= sync_reg[48] || (!cv.mode24 && diff[23:16] != 8'h00);
				end
			end
		end
	end

	assign cv.done = done_reg;
	assign cv.sat = sat_reg;
	assign cv.value = value_reg;

	AST_INTEG_MIN: assert property (@(posedge ref_clk) disable iff (!rst_q_n)
		cv.start |=> !cv.done [*8])
		else $error("conversion finished before the integration time");
endmodule // adc_integ_conv
`default_nettype wire

// file: core/light_proximity_measure_seq.sv
// Measurement sequencer for an optical ambient-light and proximity sensor.
// Assumes host command and setup ports come from logic on ref_clk, and the
// converter pins and the open-drain interrupt wire are resolved outside.
//
// Summary of operation
// - A host start command begins a measurement set at once.
// - Autonomous mode repeats sets at the programmed rate and interrupts.
// - A channel left out of the enable list, like infrared, is skipped.
// - Saturation writes 0xFFFF in 16-bit mode, 0x7FFFFF in 24-bit mode.
// - Normal values are written again once light is back in range.
// - Integration lasts 24.4 us, longer when a longer code is set.
// - Each channel holds its own integration setting.
// - Each channel may select the high signal range.
// - Signal and dark converters may run together and be subtracted.
// - A channel with any LED select set is proximity and drives LEDs.
// - Each event runs up to six channels, only the enabled ones.
// - Each channel picks its LEDs and one of two current banks.
// - Proximity results may be compared above or below a threshold.
// - Entering or leaving the upper and lower window interrupts.
// - A mode interrupts once per finished set, ignoring thresholds.
// - Three LED outputs each carry a host-set current code.
// - Each proximity channel selects one of three photodiode sizes.
// - Pending events pull the shareable open-drain interrupt low.
`timescale 1ns/1ps
`default_nettype none
`include "light_prox_params.svh"
module light_proximity_measure_seq #(
	parameter int NUM_CH = `CH_COUNT,
	parameter int INTEG_BASE_CYC = `INTEG_BASE_CYC,
	parameter int RATE_UNIT_CYC = `RATE_UNIT_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Host commands
	input wire logic start_cmd,
	input wire logic auto_enable,
	input wire logic [15:0] meas_rate,
	input wire logic irq_every_set,
	input wire logic irq_clear,
	// Channel setup
	input wire logic [NUM_CH-1:0] channel_enable_list,
	input wire logic [NUM_CH*16-1:0] chan_cfg,
	input wire logic [NUM_CH*16-1:0] chan_threshold,
	input wire logic [15:0] upper_threshold,
	input wire logic [15:0] lower_threshold,
	input wire logic [17:0] led_current_bank0,
	input wire logic [17:0] led_current_bank1,
	// Converter pins
	input wire logic [23:0] adc_sig_data,
	input wire logic [23:0] adc_dark_data,
	input wire logic adc_sat,
	// Front end control
	output logic [2:0] led_drive,
	output logic [17:0] led_current,
	output logic [1:0] pd_size,
	output logic adc_high_range,
	output logic sig_adc_run,
	output logic dark_adc_run,
	// Results and status
	output logic [NUM_CH*24-1:0] results,
	output logic [NUM_CH-1:0] overflow,
	output logic busy,
	// Open-drain interrupt
	output logic int_out,
	output logic int_oe
);
	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic rst_q_n;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_q_n = rst_sync_reg[1];

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_q_n);
	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	light_prox_pkg::seq_state_t state_reg;
	logic [2:0] ch_reg;
	logic req_reg;
	logic hit_reg;
	logic conv_start_reg;
	logic [NUM_CH-1:0] inside_reg;
	logic [31:0] unit_cnt_reg;
	logic [15:0] rate_cnt_reg;
	logic auto_fire;
	logic [15:0] cur_cfg;
	logic [23:0] cur_thr;
	logic [3:0] nx;
	logic [23:0] store_val;
	logic inside_now;
	logic hit_now;
	light_prox_pkg::irq_mode_t cur_mode;
	logic [2:0] sel_ch;
	logic [15:0] sel_cfg;

	conv_if cv ();
	// Lowest enabled channel at or above the given one, with a found flag.
	function automatic logic [3:0] next_ch(input logic [NUM_CH-1:0] list,
		input logic [2:0] from);
		logic [3:0] r;
		r = 4'h0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (list[i] && 3'(i) >= from) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction
	assign cur_cfg = chan_cfg[int'(ch_reg) * 16 +: 16];
	assign cur_thr = {8'h00, chan_threshold[int'(ch_reg) * 16 +: 16]};
	assign cur_mode = light_prox_pkg::irq_mode_t'(cur_cfg[`FLD_IRQ_LO +: 2]);
	assign nx = next_ch(channel_enable_list, ch_reg);

	// ---------------------------------------------------------------
	// Conversion timer
	// ---------------------------------------------------------------
	// per-channel integration code
	assign cv.integ_code = cur_cfg[`FLD_INTEG_LO +: 4];
	assign cv.dark_sub = cur_cfg[`FLD_DARK_SUB];
	assign cv.mode24 = cur_cfg[`FLD_MODE24];
	assign cv.start = conv_start_reg;

	adc_integ_conv #(
		.INTEG_BASE_CYC(INTEG_BASE_CYC)
	) u_conv (
		.ref_clk(ref_clk),
		.rst_q_n(rst_q_n),
		.sig_pin(adc_sig_data),
		.dark_pin(adc_dark_data),
		.sat_pin(adc_sat),
		.cv(cv)
	);

	// ---------------------------------------------------------------
	// Autonomous rate timer
	// ---------------------------------------------------------------
	// A tick that lands while a set is running is kept in the request flag,
	// so a slow set delays the next one instead of dropping it.
	assign auto_fire = auto_enable && unit_cnt_reg == 32'(RATE_UNIT_CYC - 1) &&
		(meas_rate == 16'h0000 || rate_cnt_reg >= meas_rate - 16'h0001);

	always_ff @(posedge ref_clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			unit_cnt_reg <= 32'h00000000;
			rate_cnt_reg <= 16'h0000;
		end else if (!auto_enable) begin
			unit_cnt_reg <= 32'h00000000;
			rate_cnt_reg <= 16'h0000;
		end else if (unit_cnt_reg == 32'(RATE_UNIT_CYC - 1)) begin
			unit_cnt_reg <= 32'h00000000;
			rate_cnt_reg <= auto_fire ? 16'h0000 : rate_cnt_reg + 16'h0001;
		end else begin
			unit_cnt_reg <= unit_cnt_reg + 32'h00000001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			req_reg <= 1'b0;
		end else if (start_cmd || auto_fire) begin
			req_reg <= 1'b1;
		end else if (state_reg == light_prox_pkg::S_IDLE) begin
			req_reg <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			state_reg <= light_prox_pkg::S_IDLE;
			ch_reg <= 3'h0;
			conv_start_reg <= 1'b0;
		end else begin
			conv_start_reg <= 1'b0;
			unique case (state_reg)
				light_prox_pkg::S_IDLE: begin
					ch_reg <= 3'h0;
					if (req_reg) begin
						state_reg <= light_prox_pkg::S_SETUP;
					end
				end
				light_prox_pkg::S_SETUP: begin
					if (nx[3]) begin
						ch_reg <= nx[2:0];
						conv_start_reg <= 1'b1;
						state_reg <= light_prox_pkg::S_CONV;
					end else begin
						state_reg <= light_prox_pkg::S_DONE;
					end
				end
				light_prox_pkg::S_CONV: begin
					if (cv.done) begin
						state_reg <= light_prox_pkg::S_STORE;
					end
				end
				light_prox_pkg::S_STORE: begin
					ch_reg <= ch_reg + 3'h1;
					state_reg <= light_prox_pkg::S_SETUP;
				end
				light_prox_pkg::S_DONE: begin
					state_reg <= light_prox_pkg::S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			busy <= 1'b0;
		end else begin
			busy <= state_reg != light_prox_pkg::S_IDLE;
		end
	end

	// ---------------------------------------------------------------
	// Front end drive
	// ---------------------------------------------------------------
	// Every setting follows the channel about to convert, so LEDs, converters
	// and switches change on one edge; LEDs stay dark between channels.
	assign sel_ch = state_reg == light_prox_pkg::S_SETUP ? nx[2:0] : ch_reg;
	assign sel_cfg = chan_cfg[int'(sel_ch) * 16 +: 16];
	always_ff @(posedge ref_clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			led_drive <= 3'h0;
			led_current <= 18'h00000;
			pd_size <= 2'h0;
			adc_high_range <= 1'b0;
			sig_adc_run <= 1'b0;
			dark_adc_run <= 1'b0;
		end else begin
			led_drive <= 3'h0;
			led_current <= 18'h00000;
			sig_adc_run <= 1'b0;
			dark_adc_run <= 1'b0;
			if (state_reg == light_prox_pkg::S_SETUP && nx[3] ||
				state_reg == light_prox_pkg::S_CONV && !cv.done) begin
				for (int i = 0; i < 3; i++) begin
					if (sel_cfg[i]) begin
						led_drive[i] <= 1'b1;
						led_current[i * 6 +: 6] <= sel_cfg[`FLD_BANK] ?
							led_current_bank1[i * 6 +: 6] : led_current_bank0[i * 6 +: 6];
					end
				end
				sig_adc_run <= 1'b1;
				dark_adc_run <= sel_cfg[`FLD_DARK_SUB];
				pd_size <= sel_cfg[`FLD_PD_LO +: 2];
				adc_high_range <= sel_cfg[`FLD_HIGH_RANGE];
			end
		end
	end

	// ---------------------------------------------------------------
	// Results and threshold tests
	// ---------------------------------------------------------------
	// overflow code
	assign store_val = !cv.sat ? cv.value :
		(cur_cfg[`FLD_MODE24] ? `OVF_CODE24 : `OVF_CODE16);
	assign inside_now = store_val >= {8'h00, lower_threshold} &&
		store_val <= {8'h00, upper_threshold};
	always_comb begin
		hit_now = 1'b0;
		unique case (cur_mode)
			light_prox_pkg::IRQ_ABOVE: hit_now = store_val > cur_thr;
			light_prox_pkg::IRQ_BELOW: hit_now = store_val < cur_thr;
			light_prox_pkg::IRQ_WINDOW: hit_now = inside_now != inside_reg[ch_reg];
			light_prox_pkg::IRQ_OFF: hit_now = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			results <= '0;
			overflow <= '0;
			inside_reg <= '0;
			hit_reg <= 1'b0;
		end else if (state_reg == light_prox_pkg::S_IDLE) begin
			hit_reg <= 1'b0;
		end else if (state_reg == light_prox_pkg::S_STORE) begin
			results[int'(ch_reg) * 24 +: 24] <= store_val;
			overflow[ch_reg] <= cv.sat;
			inside_reg[ch_reg] <= inside_now;
			hit_reg <= hit_reg || hit_now;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt pin
	// ---------------------------------------------------------------
	// raised only at set end
	always_ff @(posedge ref_clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			int_oe <= 1'b0;
			int_out <= 1'b0;
		end else if (state_reg == light_prox_pkg::S_DONE &&
			(irq_every_set || hit_reg)) begin
			int_oe <= 1'b1;
		end else if (irq_clear) begin
			int_oe <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_START_NOW: assert property (
		start_cmd && state_reg == light_prox_pkg::S_IDLE |=> ##1
		state_reg == light_prox_pkg::S_SETUP)
		else $error("start command did not begin a set");
	AST_ONLY_ENABLED: assert property (
		conv_start_reg |-> channel_enable_list[ch_reg])
		else $error("disabled channel was converted");
	AST_SKIP: assert property (
		state_reg == light_prox_pkg::S_SETUP && !nx[3] |=>
		state_reg == light_prox_pkg::S_DONE && !conv_start_reg)
		else $error("set did not end after the last enabled channel");
	AST_OVF_CODE: assert property (
		state_reg == light_prox_pkg::S_STORE && cv.sat |=>
		results[int'($past(ch_reg)) * 24 +: 24] ==
		($past(cur_cfg[`FLD_MODE24]) ? `OVF_CODE24 : `OVF_CODE16))
		else $error("overflow code not written");
	AST_LED_PROX: assert property (
		led_drive != 3'h0 |-> $past(state_reg) == light_prox_pkg::S_SETUP ||
		$past(state_reg) == light_prox_pkg::S_CONV)
		else $error("LED lit outside a conversion");
	AST_IRQ_AFTER_STORE: assert property (
		$rose(int_oe) |-> $past(state_reg) == light_prox_pkg::S_DONE &&
		$past(state_reg, 2) == light_prox_pkg::S_SETUP)
		else $error("interrupt raised before results were complete");
	AST_EVERY_SET: assert property (
		state_reg == light_prox_pkg::S_DONE && irq_every_set |=> int_oe)
		else $error("per-set interrupt missing");
	AST_PIN_LOW: assert property (
		int_oe && !irq_clear && state_reg != light_prox_pkg::S_DONE |=>
		int_oe && int_out == 1'b0)
		else $error("interrupt pin released without a clear");
	AST_RANGE_HELD: assert property (
		state_reg == light_prox_pkg::S_CONV ##1 state_reg == light_prox_pkg::S_CONV
		|-> adc_high_range == $past(cur_cfg[`FLD_HIGH_RANGE]))
		else $error("range select differs from the channel setting");
endmodule // light_proximity_measure_seq
`default_nettype wire

// file: tb/irq_host_model.sv
// Host-side partner: the pull-up on the shared interrupt wire and a host that clears it.
// Assumes int_oe and int_out come from the sequencer on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Interrupt pin of the sequencer
	input wire logic int_out,
	input wire logic int_oe,
	// Bench control
	input wire logic auto_clear,
	input wire logic clear_req,
	// Host view
	output logic int_wire,
	output logic irq_clear,
	output logic [7:0] irq_seen
);
	// ---------------------------------------------------------------
	// Shared wire and clearing host
	// ---------------------------------------------------------------
	logic wire_q;

	assign int_wire = int_oe ? int_out : 1'b1;

	// A lazy host clears one cycle after it sees the wire low, never twice in a row.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_clear <= 1'b0;
			irq_seen <= 8'h00;
			wire_q <= 1'b1;
		end else begin
			wire_q <= int_wire;
			irq_clear <= clear_req | (auto_clear & ~int_wire & ~irq_clear);
			if (wire_q && !int_wire) begin
				irq_seen <= irq_seen + 8'h01;
			end
		end
	end
endmodule // irq_host_model
`default_nettype wire

// file: tb/light_proximity_measure_seq_bench.sv
// Self-checking bench for the measurement sequencer.
// Assumes shortened integration and rate units; the bench acts as the converter.
`timescale 1ns/1ps
`default_nettype none
module light_proximity_measure_seq_bench;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic start_cmd = 1'b0;
	logic auto_enable = 1'b0;
	logic [15:0] meas_rate = 16'h0032;
	logic irq_every_set = 1'b1;
	logic [5:0] channel_enable_list = 6'h03;
	logic [95:0] chan_cfg = {64'h0, 16'h1c40, 16'h0029};
	logic [95:0] chan_threshold = 96'h0;
	logic [15:0] upper_threshold = 16'h4000;
	logic [15:0] lower_threshold = 16'h2000;
	logic [17:0] led_current_bank0 = 18'h15a5a;
	logic [17:0] led_current_bank1 = 18'h2c3f1;
	logic [23:0] adc_sig_data = 24'h008a5c;
	logic [23:0] adc_dark_data = 24'h001203;
	logic adc_sat = 1'b0;
	logic auto_clear = 1'b0;
	logic clear_req = 1'b0;
	wire logic [2:0] led_drive;
	wire logic [17:0] led_current;
	wire logic [1:0] pd_size;
	wire logic adc_high_range, sig_adc_run, dark_adc_run, busy, int_out, int_oe;
	wire logic [143:0] results;
	wire logic [5:0] overflow;
	wire logic int_wire, irq_clear;
	wire logic [7:0] irq_seen;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [2:0] snap_led;
	logic [17:0] snap_cur;
	logic [1:0] snap_pd;
	logic snap_hr, snap_dark;
	light_prox_pkg::irq_mode_t t_mode [8] = '{light_prox_pkg::IRQ_WINDOW,
		light_prox_pkg::IRQ_WINDOW, light_prox_pkg::IRQ_WINDOW, light_prox_pkg::IRQ_WINDOW,
		light_prox_pkg::IRQ_ABOVE, light_prox_pkg::IRQ_ABOVE,
		light_prox_pkg::IRQ_BELOW, light_prox_pkg::IRQ_BELOW};
	logic [15:0] t_thr [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1000, 16'h5000, 16'h5000, 16'h1000};
	logic [15:0] t_val [8] = '{16'h6000, 16'h3000, 16'h3800, 16'h1000,
		16'h3000, 16'h3000, 16'h3000, 16'h3000};
	logic t_exp [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

	always #4 ref_clk = ~ref_clk;

	light_proximity_measure_seq #(.NUM_CH(6), .INTEG_BASE_CYC(16), .RATE_UNIT_CYC(10)) DUT (
		.ref_clk(ref_clk), .rst_n(rst_n), .start_cmd(start_cmd), .auto_enable(auto_enable),
		.meas_rate(meas_rate), .irq_every_set(irq_every_set), .irq_clear(irq_clear),
		.channel_enable_list(channel_enable_list), .chan_cfg(chan_cfg),
		.chan_threshold(chan_threshold), .upper_threshold(upper_threshold),
		.lower_threshold(lower_threshold), .led_current_bank0(led_current_bank0),
		.led_current_bank1(led_current_bank1), .adc_sig_data(adc_sig_data),
		.adc_dark_data(adc_dark_data), .adc_sat(adc_sat), .led_drive(led_drive),
		.led_current(led_current), .pd_size(pd_size), .adc_high_range(adc_high_range),
		.sig_adc_run(sig_adc_run), .dark_adc_run(dark_adc_run), .results(results),
		.overflow(overflow), .busy(busy), .int_out(int_out), .int_oe(int_oe));

	irq_host_model host (.ref_clk(ref_clk), .rst_n(rst_n), .int_out(int_out), .int_oe(int_oe),
		.auto_clear(auto_clear), .clear_req(clear_req), .int_wire(int_wire),
		.irq_clear(irq_clear), .irq_seen(irq_seen));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (err_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic grab_run(output int len);
		int n;
		n = 0;
		while (sig_adc_run !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		snap_led = led_drive;
		snap_cur = led_current;
		snap_pd = pd_size;
		snap_hr = adc_high_range;
		snap_dark = dark_adc_run;
		len = 0;
		while (sig_adc_run === 1'b1 && len < 400) begin
			@(posedge ref_clk);
			#1;
			len++;
		end
	endtask

	// Pulses start, then waits for the set to finish and the interrupt to settle.
	task automatic run_set();
		int n;
		@(posedge ref_clk);
		start_cmd <= 1'b1;
		@(posedge ref_clk);
		start_cmd <= 1'b0;
		n = 0;
		repeat (4) @(posedge ref_clk);
		while (busy === 1'b1 && n < 2000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	task automatic host_clear();
		@(posedge ref_clk);
		clear_req <= 1'b1;
		@(posedge ref_clk);
		clear_req <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		int n;
		int len;
		int seen0;
		repeat (6) @(posedge ref_clk);
		check("busy_rst", 24'(busy), 24'h0);
		check("int_oe_rst", 24'(int_oe), 24'h0);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		start_cmd <= 1'b1;
		@(posedge ref_clk);
		start_cmd <= 1'b0;
		n = 0;
		while (busy !== 1'b1 && n < 10) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check("start_latency", 24'(n), 24'h2);
		grab_run(len);
		check("len_ch0", 24'(len >= 16 && len <= 20), 24'h1);
		check("led_ch0", 24'(snap_led), 24'h1);
		check("cur_ch0", 24'(snap_cur), 24'(led_current_bank1[5:0]));
		check("pd_ch0", 24'(snap_pd), 24'h2);
		check("range_ch0", 24'(snap_hr), 24'h0);
		grab_run(len);
		check("len_ch1", 24'(len >= 32 && len <= 36), 24'h1);
		check("led_ch1", 24'(snap_led), 24'h0);
		check("dark_ch1", 24'(snap_dark), 24'h1);
		check("range_ch1", 24'(snap_hr), 24'h1);
		n = 0;
		while (int_oe !== 1'b1 && n < 200) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check("res_ch0", results[23:0], 24'h008a5c);
		check("res_ch1", results[47:24], 24'h007859);
		for (int i = 2; i < 6; i++) begin
			check("res_skipped", results[24*i +: 24], 24'h0);
		end
		check("int_wire", 24'(int_wire), 24'h0);
		repeat (10) @(posedge ref_clk);
		#1;
		check("int_stands", 24'(int_oe), 24'h1);
		host_clear();
		check("int_cleared", 24'(int_oe), 24'h0);
		// Thresholds stay off here so no interrupt is expected from these sets.
		@(posedge ref_clk);
		irq_every_set <= 1'b0;
		adc_sat <= 1'b1;
		run_set();
		check("ovf16", results[23:0], 24'h00ffff);
		check("ovf24", results[47:24], 24'h7fffff);
		check("ovf_flags", 24'(overflow), 24'h3);
		@(posedge ref_clk);
		adc_sat <= 1'b0;
		run_set();
		check("back_ch0", results[23:0], 24'h008a5c);
		check("back_flags", 24'(overflow), 24'h0);
		check("no_int", 24'(int_oe), 24'h0);
		@(posedge ref_clk);
		channel_enable_list <= 6'h01;
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			chan_cfg[15:0] <= 16'h0029 | (16'(t_mode[i]) << 13);
			chan_threshold[15:0] <= t_thr[i];
			adc_sig_data <= 24'(t_val[i]);
			run_set();
			check("thr_int", 24'(int_oe), 24'(t_exp[i]));
			host_clear();
		end
		@(posedge ref_clk);
		chan_cfg[15:0] <= 16'h0016;
		start_cmd <= 1'b1;
		@(posedge ref_clk);
		start_cmd <= 1'b0;
		grab_run(len);
		check("led_two_three", 24'(snap_led), 24'h6);
		check("cur_bank0", 24'(snap_cur), 24'({led_current_bank0[17:6], 6'h00}));
		check("pd_one", 24'(snap_pd), 24'h1);
		repeat (4) @(posedge ref_clk);
		@(posedge ref_clk);
		chan_cfg[15:0] <= 16'h0029;
		irq_every_set <= 1'b1;
		auto_clear <= 1'b1;
		auto_enable <= 1'b1;
		#1;
		seen0 = int'(irq_seen);
		// A rate of 50 units of 10 cycles gives a set every 500 cycles.
		repeat (1700) @(posedge ref_clk);
		auto_enable <= 1'b0;
		repeat (200) @(posedge ref_clk);
		#1;
		n = int'(irq_seen) - seen0;
		check("auto_sets", 24'(n >= 3 && n <= 4), 24'h1);
		tally_and_finish();
	end
endmodule // light_proximity_measure_seq_bench
`default_nettype wire
